// file: shared/gtc_edge_if.sv
// Purpose: edge pulses from the synchroniser to the timer core
// Assumes: one clock domain
// Notes: bits 3..0 pins a..d, bit 4 external count, bit 5 sub-clock
`timescale 1ns/1ps
`default_nettype none
interface gtc_edge_if #(parameter int W = 6);
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport drv (output rise, output fall);
  modport use_ (input rise, input fall);
endinterface : gtc_edge_if
`default_nettype wire

// file: shared/gtc_pkg.sv
// Purpose: constants and types for the contention-aware 16-bit timer
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes: one number, one name
package gtc_pkg;
  // ==========================================================
  // Register map
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFS_MODE = 6'h00;
  localparam logic [5:0] OFS_IOCTL = 6'h04;
  localparam logic [5:0] OFS_STATUS = 6'h08;
  localparam logic [5:0] OFS_IRQEN = 6'h0C;
  localparam logic [5:0] OFS_CNT = 6'h10;
  localparam logic [5:0] OFS_GEN_A = 6'h14;
  localparam logic [5:0] GR_STEP = 6'h04;
  // ==========================================================
  // Fields of timer_mode_reg
  localparam int unsigned MODE_RUN = 0;
  localparam int unsigned MODE_CLR = 1;
  localparam int unsigned MODE_SRC = 2;
  localparam int unsigned MODE_BUFAC = 5;
  localparam int unsigned MODE_BUFBD = 6;
  localparam int unsigned MODE_W = 7;
  // Fields of the channel control word, one nibble each
  localparam int unsigned IO_CAP = 0;
  localparam int unsigned IO_SEL = 1;
  localparam int unsigned IO_STRIDE = 4;
  localparam logic [1:0] SEL_LO = 2'h1;
  localparam logic [1:0] SEL_HI = 2'h2;
  localparam logic [1:0] SEL_TGL = 2'h3;
  // ==========================================================
  // Reset values
  localparam logic [6:0] MODE_RST = 7'h00;
  localparam logic [15:0] IOCTL_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    SRC_PHI = 3'h0, SRC_PHI2 = 3'h1, SRC_PHI4 = 3'h2, SRC_PHI8 = 3'h3,
    SRC_SUB = 3'h4, SRC_SUB4 = 3'h5, SRC_SUB16 = 3'h6, SRC_EXT = 3'h7
  } gtc_src_t;
  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'h0, PWR_SLEEP = 3'h1, PWR_SUBACT = 3'h2,
    PWR_SUBSLP = 3'h3, PWR_STANDBY = 3'h4, PWR_WATCH = 3'h5
  } gtc_pwr_t;
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} gtc_bus_t;
endpackage : gtc_pkg

// file: verif/gtc_pin_model.sv
// Purpose: far-side model of the timer pins, sub-clock and count input
// Assumes: one system clock; the bench asks for pulses by task call
// Notes: every pulse stands three clocks high and three clocks low
`timescale 1ns/1ps
`default_nettype none
module gtc_pin_model (
  input wire logic i_clk,
  output logic o_sub_clk,
  output logic o_ext,
  output logic [3:0] o_pin
);
  logic [2:0] div_r = 3'h0;
  logic [4:0] drv_r = 5'h00;

  // ==========================================================
  // Sub-clock at a eighth of the system clock, free running like a crystal
  always_ff @(posedge i_clk)
    div_r <= div_r + 3'h1;
  assign o_sub_clk = div_r[2];

  // Bits 3..0 pins a..d, bit 4 the external count input
  assign o_pin = drv_r[3:0];
  assign o_ext = drv_r[4];

  // ==========================================================
  // One pulse on a line; three clocks each way leaves margin over two
  task automatic pulse(input int idx);
    @(posedge i_clk);
    drv_r[idx] <= 1'b1;
    repeat (3) @(posedge i_clk);
    drv_r[idx] <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : pulse
endmodule : gtc_pin_model
`default_nettype wire

// file: verif/tb.sv
// Purpose: self-checking bench for the contention-aware timer
// Assumes: Wishbone ack after one wait cycle; pins from the pin model
// Notes: the counter-gating table walks every clock-source family
`timescale 1ns/1ps
`default_nettype none
module tb
  import gtc_pkg::*;
;
  logic i_clk;
  logic i_rst;
  logic i_wb_cyc;
  logic i_wb_stb;
  logic i_wb_we;
  logic [5:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat;
  logic [31:0] o_wb_dat;
  logic o_wb_ack;
  gtc_pwr_t i_pwr_mode;
  logic i_osc_stab;
  logic sub_clk;
  logic ext_in;
  logic [3:0] pin_in;
  logic [3:0] o_timer_pin;
  logic [3:0] o_timer_pin_oe;
  logic o_irq;
  int err_total = 0;
  int samples_checked = 0;
  logic [31:0] q;
  logic [31:0] c1;
  // Gating table: source, power mode, settling flag, counter should move
  gtc_src_t t_src [10] = '{SRC_PHI, SRC_PHI2, SRC_PHI4, SRC_PHI8, SRC_SUB, SRC_SUB4,
                           SRC_SUB16, SRC_SUB, SRC_EXT, SRC_EXT};
  gtc_pwr_t t_pwr [10] = '{PWR_ACTIVE, PWR_SLEEP, PWR_SUBACT, PWR_STANDBY, PWR_SUBACT,
                           PWR_SUBSLP, PWR_WATCH, PWR_ACTIVE, PWR_SUBSLP, PWR_STANDBY};
  logic t_osc [10] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic t_mv [10] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

  // ==========================================================
  // Design and far side
  gtc_timer i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_pwr_mode(i_pwr_mode),
    .i_osc_stab(i_osc_stab), .i_sub_clk(sub_clk), .i_external_count_input(ext_in),
    .i_timer_pin(pin_in), .o_timer_pin(o_timer_pin), .o_timer_pin_oe(o_timer_pin_oe),
    .o_irq(o_irq));
  gtc_pin_model i_model (.i_clk(i_clk), .o_sub_clk(sub_clk), .o_ext(ext_in), .o_pin(pin_in));

  // ==========================================================
  // Bus tasks; the request stands until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                         output logic [31:0] r);
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_sel <= 4'hF;
    i_wb_dat <= d;
    // No cycle count assumed; only the watchdog ends a hang
    do
      @(posedge i_clk);
    while (o_wb_ack !== 1'b1);
    r = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb_xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] r);
    wb_xfer(1'b0, a, 32'h0000_0000, r);
  endtask : rd

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  // ==========================================================
  // Clock and watchdog; the tests need about 1300 cycles, the watchdog allows 20000
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial
  begin
    #200000;
    err_total++;
    $display("[FAIL] run_end expected done seen hang");
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    i_rst = 1'b1;
    i_wb_cyc = 1'b0;
    i_wb_stb = 1'b0;
    i_wb_we = 1'b0;
    i_wb_adr = 6'h00;
    i_wb_sel = 4'hF;
    i_wb_dat = 32'h0000_0000;
    i_pwr_mode = PWR_ACTIVE;
    i_osc_stab = 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    // Reset values, an unmapped hole reads zero
    rd(OFS_MODE, q);
    check("mode_rst", q, {25'h0000000, MODE_RST});
    rd(OFS_CNT, q);
    check("cnt_rst", q, {16'h0000, CNT_RST});
    for (int k = 0; k < 4; k++)
    begin
      rd(6'(OFS_GEN_A + GR_STEP * k), q);
      check("gr_rst", q, {16'h0000, GR_RST});
    end
    wr(6'h3C, 32'hFFFF_FFFF);
    rd(6'h3C, q);
    check("unmapped", q, 32'h0000_0000);
    check("oe_rst", {28'h0000000, o_timer_pin_oe}, 32'h0000_0000);
    // Counter write while stopped
    wr(OFS_CNT, 32'h0000_0055);
    rd(OFS_CNT, q);
    check("cnt_wr", q, 32'h0000_0055);
    // Capture on pin a rise with the counter stopped
    wr(OFS_IOCTL, 32'h0000_0003);
    wr(OFS_IRQEN, 32'h0000_0001);
    i_model.pulse(0);
    rd(OFS_GEN_A, q);
    check("cap_val", q, 32'h0000_0055);
    check("irq_on", {31'h0, o_irq}, 32'h0000_0001);
    // Zero written without a prior read must not clear the flag
    wr(OFS_STATUS, 32'h0000_0000);
    rd(OFS_STATUS, q);
    check("flag_kept", q, 32'h0000_0001);
    wr(OFS_STATUS, 32'h0000_0000);
    rd(OFS_STATUS, q);
    check("flag_clr", q, 32'h0000_0000);
    check("irq_off", {31'h0, o_irq}, 32'h0000_0000);
    // Counting gated by source, power mode and oscillator settling
    for (int k = 0; k < 10; k++)
    begin
      @(posedge i_clk);
      i_pwr_mode <= t_pwr[k];
      i_osc_stab <= t_osc[k];
      rd(OFS_CNT, c1);
      wr(OFS_MODE, {27'h0000000, t_src[k], 2'b01});
      repeat (5) i_model.pulse(4);
      repeat (60) @(posedge i_clk);
      wr(OFS_MODE, {27'h0000000, t_src[k], 2'b00});
      rd(OFS_CNT, q);
      check("cnt_gate", {31'h0, q !== c1}, {31'h0, t_mv[k]});
    end
    @(posedge i_clk);
    i_pwr_mode <= PWR_ACTIVE;
    i_osc_stab <= 1'b0;
    // Compare on pin b drives one; its flag stays masked from the request
    wr(OFS_CNT, 32'h0000_0000);
    // Park A out of reach so only B can raise a flag
    wr(OFS_GEN_A, 32'h0000_FFFF);
    wr(6'(OFS_GEN_A + GR_STEP), 32'h0000_0020);
    wr(OFS_IOCTL, 32'h0000_0040);
    // Control writes land at the ack edge; look once settled
    @(negedge i_clk);
    check("oe_b", {28'h0000000, o_timer_pin_oe}, 32'h0000_0002);
    wr(OFS_MODE, 32'h0000_0001);
    check("pin_b_pre", {31'h0, o_timer_pin[1]}, 32'h0000_0000);
    repeat (120) @(posedge i_clk);
    check("pin_b_set", {31'h0, o_timer_pin[1]}, 32'h0000_0001);
    rd(OFS_STATUS, q);
    check("flag_b", q & 32'h0000_0002, 32'h0000_0002);
    check("irq_mask", {31'h0, o_irq}, 32'h0000_0000);
    // Requests masked before the block is parked in module standby
    wr(OFS_IRQEN, 32'h0000_0002);
    @(negedge i_clk);
    check("irq_b_on", {31'h0, o_irq}, 32'h0000_0001);
    wr(OFS_IRQEN, 32'h0000_0000);
    @(negedge i_clk);
    check("irq_parked", {31'h0, o_irq}, 32'h0000_0000);
    complete_run();
  end
endmodule : tb
`default_nettype wire

// file: verilog/gtc_cnt_src.sv
// Purpose: count tick from the selected source, gated by power mode
// Assumes: sub and external edges already synchronised
// Notes: a source switch that looks like a rising edge counts once
`timescale 1ns/1ps
`default_nettype none
module gtc_cnt_src
  import gtc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire gtc_pkg::gtc_src_t i_src,
  input wire logic i_run,
  input wire gtc_pkg::gtc_pwr_t i_pwr,
  input wire logic i_osc_stab,
  input wire logic i_ext_rise,
  input wire logic i_sub_rise,
  output logic o_tick
);
  logic [2:0] presc_r;
  logic [3:0] subdiv_r;
  logic lvl;
  logic lvl_r;
  logic raw;
  logic slow;
  logic ok;
  // ==========================================================
  // Dividers of system clock and sub-clock
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      presc_r <= '0;
      subdiv_r <= '0;
      lvl_r <= 1'b0;
    end
    else
    begin
      presc_r <= presc_r + 3'h1;
      if (i_sub_rise)
        subdiv_r <= subdiv_r + 4'h1;
      lvl_r <= lvl;
    end
  end
  // Level of the selected divided clock; its rise is the tick
  always_comb
  begin
    lvl = 1'b0;
    raw = 1'b0;
    case (i_src)
      SRC_PHI: raw = 1'b1;
      SRC_PHI2: lvl = presc_r[0];
      SRC_PHI4: lvl = presc_r[1];
      SRC_PHI8: lvl = presc_r[2];
      SRC_SUB: raw = i_sub_rise;
      SRC_SUB4: lvl = subdiv_r[1];
      SRC_SUB16: lvl = subdiv_r[3];
      SRC_EXT: raw = i_ext_rise;
      default: raw = 1'b0;
    endcase
    if (lvl && !lvl_r)
      raw = 1'b1;
  end
  // Slow sources run in sub modes but wait out oscillator settling;
  // a count may slip at the active to subactive step
  assign slow = i_src[2];
  assign ok = slow ? ((i_pwr == PWR_ACTIVE || i_pwr == PWR_SLEEP ||
               i_pwr == PWR_SUBACT || i_pwr == PWR_SUBSLP) && !i_osc_stab)
             : (i_pwr == PWR_ACTIVE || i_pwr == PWR_SLEEP);
  assign o_tick = raw && ok && i_run;
  // ==========================================================
  // Checks
  property p_stab_hold;
    @(posedge i_clk) disable iff (i_rst) (slow && i_osc_stab) |-> !o_tick;
  endproperty
  a_stab_hold: assert property (p_stab_hold) else $error("tick in settling");
  property p_fast_sub;
    @(posedge i_clk) disable iff (i_rst)
      (!slow && (i_pwr == PWR_SUBACT || i_pwr == PWR_SUBSLP)) |-> !o_tick;
  endproperty
  a_fast_sub: assert property (p_fast_sub) else $error("fast tick in sub");
endmodule : gtc_cnt_src
`default_nettype wire

// file: verilog/gtc_sync_edge.sv
// Purpose: two-flop synchroniser plus edge detect for pin inputs
// Assumes: inputs asynchronous to i_clk
// Notes: edges come from the second and third stage only
`timescale 1ns/1ps
`default_nettype none
module gtc_sync_edge #(parameter int W = 6) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  gtc_edge_if.drv edges
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  // ==========================================================
  // Sync chain; s1 feeds only s2
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Edge pulses on synchronised levels
  assign edges.rise = s2_r & ~s3_r;
  assign edges.fall = ~s2_r & s3_r;
endmodule : gtc_sync_edge
`default_nettype wire

// file: verilog/gtc_timer.sv
// Purpose: 16-bit timer core with CPU/event contention handling
// Assumes: classic Wishbone slave, one cycle wait before ack
// Notes: pins a..d are vectors bit 0..3
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gtc_timer
  import gtc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [gtc_pkg::ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire gtc_pkg::gtc_pwr_t i_pwr_mode,
  input wire logic i_osc_stab,
  input wire logic i_sub_clk,
  input wire logic i_external_count_input,
  input wire logic [3:0] i_timer_pin,
  output logic [3:0] o_timer_pin,
  output logic [3:0] o_timer_pin_oe,
  output logic o_irq
);
  // ==========================================================
  // Helpers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
      res[7:0] = dat[7:0];
    if (sel[1])
      res[15:8] = dat[15:8];
    return res;
  endfunction : merge16

  function automatic logic [5:0] gr_ofs(input int idx);
    return OFS_GEN_A + 6'(idx) * GR_STEP;
  endfunction : gr_ofs

  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic rise,
                                    input logic fall);
    return (sel[0] && rise) || (sel[1] && fall);
  endfunction : edge_hit

  gtc_bus_t bus_r;
  gtc_bus_t bus_nxt;
  logic [6:0] mode_r;
  logic [15:0] ioctl_r;
  logic [3:0] flag_r;
  logic [3:0] arm_r;
  logic [3:0] irqen_r;
  logic [15:0] cnt_r;
  logic [15:0] gr_r [0:3];
  logic [3:0] pin_r;
  logic [31:0] rdat_r;
  logic [31:0] rd_mux;
  logic take;
  logic take_rd;
  logic wr_commit;
  logic wr_cnt;
  logic wr_stat;
  logic [3:0] wr_gr;
  logic [3:0] is_cap;
  logic [1:0] sel [0:3];
  logic [3:0] bufm;
  logic [3:0] cap_ev;
  logic [3:0] match;
  logic [3:0] set_ev;
  logic [3:0] clr_ev;
  logic clr;
  logic tick;
  gtc_edge_if #(.W(6)) edges ();

  // ==========================================================
  // Input synchroniser and count source
  gtc_sync_edge #(.W(6)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_sub_clk, i_external_count_input, i_timer_pin}),
    .edges(edges.drv)
  );

  gtc_cnt_src u_src (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_src(gtc_src_t'(mode_r[MODE_SRC +: 3])),
    .i_run(mode_r[MODE_RUN]),
    .i_pwr(i_pwr_mode),
    .i_osc_stab(i_osc_stab),
    .i_ext_rise(edges.rise[4]),
    .i_sub_rise(edges.rise[5]),
    .o_tick(tick)
  );

  // ==========================================================
  // Bus slave: take in idle, ack next cycle, write lands on ack
  always_comb
  begin
    case (bus_r)
      BUS_IDLE: bus_nxt = (i_wb_cyc && i_wb_stb) ? BUS_ACK : BUS_IDLE;
      BUS_ACK: bus_nxt = BUS_IDLE;
      default: bus_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      bus_r <= BUS_IDLE;
    else
      bus_r <= bus_nxt;
  end

  assign take = (bus_r == BUS_IDLE) && i_wb_cyc && i_wb_stb;
  assign take_rd = take && !i_wb_we;
  assign wr_commit = (bus_r == BUS_ACK) && i_wb_cyc && i_wb_stb && i_wb_we;
  assign wr_cnt = wr_commit && (i_wb_adr == OFS_CNT);
  assign wr_stat = wr_commit && (i_wb_adr == OFS_STATUS) && i_wb_sel[0];
  assign o_wb_ack = (bus_r == BUS_ACK);
  assign o_wb_dat = rdat_r;

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (i_wb_adr)
      OFS_MODE: rd_mux = {25'h0, mode_r};
      OFS_IOCTL: rd_mux = {16'h0, ioctl_r};
      OFS_STATUS: rd_mux = {28'h0, flag_r};
      OFS_IRQEN: rd_mux = {28'h0, irqen_r};
      OFS_CNT: rd_mux = {16'h0, cnt_r};
      default: rd_mux = 32'h0000_0000;
    endcase
    for (int i = 0; i < 4; i++)
      if (i_wb_adr == gr_ofs(i))
        rd_mux = {16'h0, gr_r[i]};
  end

  // Sampled at take, so a same-cycle capture is not seen
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rdat_r <= 32'h0000_0000;
    else if (take_rd)
      rdat_r <= rd_mux;
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      mode_r <= MODE_RST;
      ioctl_r <= IOCTL_RST;
      irqen_r <= 4'h0;
    end
    else if (wr_commit)
    begin
      if (i_wb_adr == OFS_MODE && i_wb_sel[0])
        mode_r <= i_wb_dat[6:0];
      if (i_wb_adr == OFS_IOCTL)
        ioctl_r <= merge16(ioctl_r, i_wb_dat, i_wb_sel);
      if (i_wb_adr == OFS_IRQEN && i_wb_sel[0])
        irqen_r <= i_wb_dat[3:0];
    end
  end

  // ==========================================================
  // Channel decode and events
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      wr_gr[i] = wr_commit && (i_wb_adr == gr_ofs(i));
      is_cap[i] = ioctl_r[i * IO_STRIDE + IO_CAP];
      sel[i] = ioctl_r[i * IO_STRIDE + IO_SEL +: 2];
      bufm[i] = mode_r[(i % 2 == 0) ? MODE_BUFAC : MODE_BUFBD];
      // C and D used as buffers do not capture on their own pins
      cap_ev[i] = is_cap[i] && edge_hit(sel[i], edges.rise[i], edges.fall[i])
                  && !(i >= 2 && bufm[i]);
      // Match on the tick that moves the counter off the value
      match[i] = !is_cap[i] && tick && (cnt_r == gr_r[i]);
    end
  end

  assign clr = match[0] && mode_r[MODE_CLR];

  // ==========================================================
  // Counter: clear beats write, write beats count-up
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      cnt_r <= CNT_RST;
    else if (clr)
      cnt_r <= CNT_RST;
    else if (wr_cnt)
      cnt_r <= merge16(cnt_r, i_wb_dat, i_wb_sel);
    else if (tick)
      cnt_r <= cnt_r + 16'h0001;
  end

  // ==========================================================
  // General registers with buffer transfers
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < 4; i++)
        gr_r[i] <= GR_RST;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        // Primary A/B
        if (wr_gr[i])
          gr_r[i] <= merge16(gr_r[i], i_wb_dat, i_wb_sel);
        else if (cap_ev[i])
          gr_r[i] <= cnt_r;
        else if (match[i] && bufm[i])
          gr_r[i] <= gr_r[i + 2];
        // Buffer C/D
        if (wr_gr[i + 2])
          gr_r[i + 2] <= merge16(gr_r[i + 2], i_wb_dat, i_wb_sel);
        else if (bufm[i] && cap_ev[i])
          gr_r[i + 2] <= gr_r[i];
        else if (cap_ev[i + 2])
          gr_r[i + 2] <= cnt_r;
      end
    end
  end

  // ==========================================================
  // Compare outputs follow every match, write or not
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      pin_r <= 4'h0;
    else
    begin
      for (int i = 0; i < 4; i++)
        if (match[i])
          case (sel[i])
            SEL_LO: pin_r[i] <= 1'b0;
            SEL_HI: pin_r[i] <= 1'b1;
            SEL_TGL: pin_r[i] <= ~pin_r[i];
            default: pin_r[i] <= pin_r[i];
          endcase
    end
  end

  assign o_timer_pin = pin_r;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      o_timer_pin_oe[i] = !is_cap[i] && (sel[i] != 2'h0);
  end

  // ==========================================================
  // Status flags: set beats clear; clear needs an earlier read of one
  assign set_ev = cap_ev | match;
  assign clr_ev = (wr_stat ? ~i_wb_dat[3:0] : 4'h0) & arm_r;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      flag_r <= 4'h0;
      arm_r <= 4'h0;
    end
    else
    begin
      flag_r <= (flag_r & ~clr_ev) | set_ev;
      if (take_rd && i_wb_adr == OFS_STATUS)
        arm_r <= flag_r;
      else if (wr_stat)
        arm_r <= 4'h0;
    end
  end

  // Request line; software masks it before module standby
  assign o_irq = |(flag_r & irqen_r);

  // ==========================================================
  // Checks
  sequence s_rd_take(logic [5:0] ofs);
    take_rd && (i_wb_adr == ofs);
  endsequence
  sequence s_ack_then_drop;
    o_wb_ack ##1 !o_wb_ack;
  endsequence

  property p_bus_ack;
    @(posedge i_clk) disable iff (i_rst) take |=> s_ack_then_drop;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("ack timing");

  property p_clr_wins;
    @(posedge i_clk) disable iff (i_rst) (clr && wr_cnt) |=> cnt_r == CNT_RST;
  endproperty
  a_clr_wins: assert property (p_clr_wins) else $error("clear lost");

  property p_wr_beats_tick;
    @(posedge i_clk) disable iff (i_rst)
      (wr_cnt && tick && !clr && i_wb_sel == 4'hF) |=> cnt_r == $past(i_wb_dat[15:0]);
  endproperty
  a_wr_beats_tick: assert property (p_wr_beats_tick) else $error("count beat write");

  property p_cap_flag;
    @(posedge i_clk) disable iff (i_rst) cap_ev[0] |=> flag_r[0];
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("capture flag lost");

  property p_wr_over_cap;
    @(posedge i_clk) disable iff (i_rst) (wr_gr[1] && cap_ev[1] && i_wb_sel == 4'hF)
      |=> (gr_r[1] == $past(i_wb_dat[15:0])) && flag_r[1];
  endproperty
  a_wr_over_cap: assert property (p_wr_over_cap) else $error("capture beat write");

  property p_rd_old;
    @(posedge i_clk) disable iff (i_rst)
      (s_rd_take(OFS_GEN_A) and cap_ev[0]) |=> o_wb_dat[15:0] == $past(gr_r[0]) ##1 1'b1;
  endproperty
  a_rd_old: assert property (p_rd_old) else $error("read saw capture");

  property p_buf_cap;
    @(posedge i_clk) disable iff (i_rst)
      (cap_ev[0] && bufm[0] && wr_gr[2] && i_wb_sel == 4'hF)
      |=> (gr_r[0] == $past(cnt_r)) && (gr_r[2] == $past(i_wb_dat[15:0]));
  endproperty
  a_buf_cap: assert property (p_buf_cap) else $error("buffer capture clash");

  property p_pin_hi;
    @(posedge i_clk) disable iff (i_rst) (match[1] && sel[1] == SEL_HI) |=> o_timer_pin[1];
  endproperty
  a_pin_hi: assert property (p_pin_hi) else $error("pin missed match");

  property p_buf_cmp;
    @(posedge i_clk) disable iff (i_rst)
      (match[0] && bufm[0] && wr_gr[2] && !wr_gr[0]) |=> gr_r[0] == $past(gr_r[2]);
  endproperty
  a_buf_cmp: assert property (p_buf_cmp) else $error("buffer took new value");

  property p_match_time;
    @(posedge i_clk) disable iff (i_rst)
      (tick && !is_cap[2] && cnt_r == gr_r[2]) |=> flag_r[2];
  endproperty
  a_match_time: assert property (p_match_time) else $error("match flag late");

  property p_no_blind_clr;
    @(posedge i_clk) disable iff (i_rst)
      (flag_r[0] && !arm_r[0]) |=> flag_r[0];
  endproperty
  a_no_blind_clr: assert property (p_no_blind_clr) else $error("flag cleared unread");
endmodule : gtc_timer
`default_nettype wire
